// *** rtl/tccu_top.sv ***
// Notes on behaviour
// - Edge field: 00 rising, 01 falling, 10 both; 11 must not be used.
// - Channel A trigger select: 0 slow oscillator, 1 channel A pin.
// - Trigger select acts only while channel A is in capture.
// - Capture latches counter; buffered C/D take old A/B value.
// - Compare: counter equal to general register drives the pin.
// - Clear off: 65,536 period; clear on: zero on A match or capture.
// - Run bit starts and stops; stopped pins hold; stopped counter holds unless clear on zeroes it on A capture.
// - Stop-at-match halts counting at channel A compare match.
// - Requests on every match, every capture and every overflow.
// - Initial levels drive the pins when control one is written.
// - Three-bit field picks f1,f2,f4,f8,f32,ext pin,fast,alternate.
// - Control one bit 7 enables clearing on channel A match.
// - Buffered compare: C/D hold the next compare value for A/B.
// - Counter is readable and writable at any time.
// - Bit 7 of the A/B control register reads as 1.
// - Each compare channel can drive low, drive high or toggle.
// - Output field: 00 off, 01 low, 10 high, 11 toggle.
// - Buffered compare copies C/D into A/B on A/B match.
// - Buffered capture moves old A/B into C/D on capture.
`timescale 1ns/10ps
`include "tccu_params.svh"
module tccu_top (
  input  wire logic                    ref_clk,             // 250 MHz clock
  input  wire logic                    rst_n,               // Async reset
  input  wire logic                    ce,                  // Clock enable
  input  wire tccu_pkg::tccu_bus_req_t bus_req,             // Register request
  output tccu_pkg::tccu_pin_drv_t      pin_drv,             // Channel pin drive
  output tccu_pkg::tccu_evt_t          evt_req,             // Request pulses
  output logic [15:0]                  rd_data,             // Read data
  input  wire logic [3:0]              channel_pin_in,      // Channel pin levels
  input  wire logic                    external_count_pin,  // External clock pin
  input  wire logic                    slow_osc_divided,    // Capture trigger
  input  wire logic                    fast_osc_clock,      // Fast oscillator
  input  wire logic                    alternate_osc_clock  // Alternate oscillator
);
  import tccu_pkg::*;

  logic [7:0]            mode_register;
  logic [7:0]            counter_control_one;
  logic [7:0]            counter_control_two;
  logic [7:0]            channel_ab_io_control;
  logic [7:0]            channel_cd_io_control;
  logic [15:0]           main_counter;
  logic [15:0]           gen_reg [4];
  logic [`TCCU_PSC_W-1:0] psc;
  logic [15:0]           rd_mux;
  logic [15:0]           next_counter;
  logic [3:0]            next_pin_out;

  wire [7:0] edge_rise;
  wire [7:0] edge_fall;

  // Synchronised edges: pins, ext clock, slow, fast and alternate oscillators
  tccu_sync_edge #(.N(8)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({alternate_osc_clock, fast_osc_clock, slow_osc_divided,
                external_count_pin, channel_pin_in}),
    .rise     (edge_rise),
    .fall     (edge_fall)
  );

  // Register strobes
  wire wr_mode = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_MODE);
  wire wr_ctl1 = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_CTL1);
  wire wr_ctl2 = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_CTL2);
  wire wr_ioab = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_IOAB);
  wire wr_iocd = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_IOCD);
  wire wr_cnt  = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_CNT);
  wire [3:0] wr_gr;
  assign wr_gr[0] = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_GRA);
  assign wr_gr[1] = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_GRB);
  assign wr_gr[2] = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_GRC);
  assign wr_gr[3] = ce & bus_req.wr & (bus_req.addr == `TCCU_OFF_GRD);

  // Control fields
  wire       run_bit           = mode_register[`TCCU_MODE_RUN];
  wire [1:0] buf_en            = {mode_register[`TCCU_MODE_BFD],
                                  mode_register[`TCCU_MODE_BFC]};
  wire       clear_select_bit  = counter_control_one[`TCCU_CTL1_CLR];
  wire       stop_at_match_bit = counter_control_two[`TCCU_CTL2_STOP];
  tccu_src_t src_sel;
  assign src_sel = tccu_src_t'(counter_control_one[`TCCU_CTL1_SRC]);

  // Count source tick
  logic src_tick;
  always_comb begin
    case (src_sel)
      TCCU_SRC_F1:   src_tick = ce;
      TCCU_SRC_F2:   src_tick = ce & ((psc & `TCCU_PSC_D2) == `TCCU_PSC_D2);
      TCCU_SRC_F4:   src_tick = ce & ((psc & `TCCU_PSC_D4) == `TCCU_PSC_D4);
      TCCU_SRC_F8:   src_tick = ce & ((psc & `TCCU_PSC_D8) == `TCCU_PSC_D8);
      TCCU_SRC_F32:  src_tick = ce & (psc == `TCCU_PSC_D32);
      TCCU_SRC_EXT:  src_tick = edge_rise[4];
      TCCU_SRC_FAST: src_tick = edge_rise[6];
      default:       src_tick = edge_rise[7];
    endcase
  end
  wire tick = run_bit & src_tick;

  // Free-running prescaler for the divided sources
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc <= '0;
    end else if (ce) begin
      psc <= psc + 1'b1;
    end
  end

  // Per-channel capture and compare decode
  logic [3:0] mode_sel;
  logic [3:0] cap_evt;
  logic [3:0] cmp_hit;
  logic [3:0] drive_en;
  tccu_act_t  act [4];

  for (genvar j = 0; j < 4; j++) begin : g_chan
    localparam int P = j ^ 2;
    wire [3:0] cfg = (j < 2) ? channel_ab_io_control[4*(j%2) +: 4]
                             : channel_cd_io_control[4*(j%2) +: 4];
    tccu_edge_t edge_sel;
    assign edge_sel    = tccu_edge_t'(cfg[`TCCU_CH_EDGE]);
    assign mode_sel[j] = cfg[`TCCU_CH_MODE];
    assign act[j]      = tccu_act_t'(cfg[`TCCU_CH_EDGE]);
    // Channel A may take the slow oscillator instead of its pin
    wire use_pin = (j != 0) | ~mode_sel[j] | cfg[`TCCU_CH_FUNC];
    wire s_rise  = use_pin ? edge_rise[j] : edge_rise[5];
    wire s_fall  = use_pin ? edge_fall[j] : edge_fall[5];
    // Valid edge in capture operation
    assign cap_evt[j] = mode_sel[j] & (
                        ((edge_sel == TCCU_EDGE_RISE) & s_rise) |
                        ((edge_sel == TCCU_EDGE_FALL) & s_fall) |
                        ((edge_sel == TCCU_EDGE_BOTH) & (s_rise | s_fall)));
    // Equality in compare operation
    assign cmp_hit[j] = tick & ~mode_sel[j] & (main_counter == gen_reg[j]);
    // Buffered C and D give up their own pins
    assign drive_en[j] = ~mode_sel[j] & (act[j] != TCCU_ACT_OFF) &
                         ~((j >= 2) & buf_en[j%2]);

    // General register update: hardware transfer beats a software write
    if (j < 2) begin : g_main
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          gen_reg[j] <= `TCCU_RST_GR;
        end else if (cap_evt[j]) begin
          gen_reg[j] <= main_counter;
        end else if (cmp_hit[j] & buf_en[j]) begin
          gen_reg[j] <= gen_reg[P];
        end else if (wr_gr[j]) begin
          gen_reg[j] <= bus_req.wdata;
        end
      end
    end else begin : g_buf
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          gen_reg[j] <= `TCCU_RST_GR;
        end else if (buf_en[j%2] & cap_evt[P]) begin
          gen_reg[j] <= gen_reg[P];
        end else if (~buf_en[j%2] & cap_evt[j]) begin
          gen_reg[j] <= main_counter;
        end else if (wr_gr[j]) begin
          gen_reg[j] <= bus_req.wdata;
        end
      end
    end

    // Pin level on match
    always_comb begin
      case (act[j])
        TCCU_ACT_LOW:    next_pin_out[j] = 1'b0;
        TCCU_ACT_HIGH:   next_pin_out[j] = 1'b1;
        TCCU_ACT_TOGGLE: next_pin_out[j] = ~pin_drv.out[j];
        default:         next_pin_out[j] = pin_drv.out[j];
      endcase
    end
  end

  // Counter clear and wrap
  wire a_clear   = clear_select_bit & (cmp_hit[0] | cap_evt[0]);
  wire cnt_wrap  = tick & (main_counter == `TCCU_CNT_MAX) & ~a_clear;
  always_comb begin
    if (wr_cnt) begin
      next_counter = bus_req.wdata;
    end else if (a_clear) begin
      next_counter = 16'h0000;
    end else if (tick) begin
      next_counter = main_counter + 16'h0001;
    end else begin
      next_counter = main_counter;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_counter <= `TCCU_RST_CNT;
    end else if (ce) begin
      main_counter <= next_counter;
    end
  end

  // Mode register; stop-at-match clears the run bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_register <= `TCCU_RST_MODE;
    end else if (stop_at_match_bit & cmp_hit[0]) begin
      mode_register[`TCCU_MODE_RUN] <= 1'b0;
    end else if (wr_mode) begin
      mode_register <= bus_req.wdata[7:0] & `TCCU_MODE_MASK;
    end
  end

  // Control and I/O control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_control_one   <= `TCCU_RST_CTL1;
      counter_control_two   <= `TCCU_RST_CTL2;
      channel_ab_io_control <= `TCCU_RST_IOAB;
      channel_cd_io_control <= `TCCU_RST_IOCD;
    end else begin
      if (wr_ctl1) counter_control_one <= bus_req.wdata[7:0];
      if (wr_ctl2) counter_control_two <= (bus_req.wdata[7:0] & `TCCU_CTL2_MASK) |
                                          `TCCU_CTL2_ONES;
      if (wr_ioab) channel_ab_io_control <= bus_req.wdata[7:0] | `TCCU_IOAB_ONES;
      if (wr_iocd) channel_cd_io_control <= bus_req.wdata[7:0];
    end
  end

  // Pin drive: control one write loads initial levels, else match action
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_drv <= '0;
    end else if (ce) begin
      pin_drv.oe <= drive_en;
      if (wr_ctl1) begin
        pin_drv.out <= bus_req.wdata[`TCCU_CTL1_INIT];
      end else begin
        pin_drv.out <= (cmp_hit & drive_en & next_pin_out) |
                       (~(cmp_hit & drive_en) & pin_drv.out);
      end
    end
  end

  // Request pulses for matches, captures and overflow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_req <= '0;
    end else if (ce) begin
      evt_req.chan <= cmp_hit | cap_evt;
      evt_req.ovf  <= cnt_wrap;
    end
  end

  // Read decode
  always_comb begin
    if (bus_req.addr == `TCCU_OFF_MODE) begin
      rd_mux = {8'h00, mode_register};
    end else if (bus_req.addr == `TCCU_OFF_CTL1) begin
      rd_mux = {8'h00, counter_control_one};
    end else if (bus_req.addr == `TCCU_OFF_CTL2) begin
      rd_mux = {8'h00, counter_control_two};
    end else if (bus_req.addr == `TCCU_OFF_IOAB) begin
      rd_mux = {8'h00, channel_ab_io_control};
    end else if (bus_req.addr == `TCCU_OFF_IOCD) begin
      rd_mux = {8'h00, channel_cd_io_control};
    end else if (bus_req.addr == `TCCU_OFF_CNT) begin
      rd_mux = main_counter;
    end else if (bus_req.addr == `TCCU_OFF_GRA) begin
      rd_mux = gen_reg[0];
    end else if (bus_req.addr == `TCCU_OFF_GRB) begin
      rd_mux = gen_reg[1];
    end else if (bus_req.addr == `TCCU_OFF_GRC) begin
      rd_mux = gen_reg[2];
    end else if (bus_req.addr == `TCCU_OFF_GRD) begin
      rd_mux = gen_reg[3];
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Read data stands in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (ce & bus_req.rd) begin
      rd_data <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cap_a;
    ce && cap_evt[0] && !clear_select_bit;
  endsequence
  sequence s_rd_ab;
    ce && bus_req.rd && bus_req.addr == `TCCU_OFF_IOAB;
  endsequence

  a_cap_latch: assert property (s_cap_a |=> gen_reg[0] == $past(main_counter))
    else $error("capture did not latch the counter");
  a_cap_buffer_move: assert property (ce && cap_evt[0] && buf_en[0]
    |=> gen_reg[2] == $past(gen_reg[0]))
    else $error("buffered capture did not move old value");
  a_cmp_buffer_load: assert property (ce && cmp_hit[0] && buf_en[0] && !cap_evt[0]
    |=> gen_reg[0] == $past(gen_reg[2]))
    else $error("buffered compare did not load next value");
  a_clear_on_match: assert property (ce && cmp_hit[0] && clear_select_bit && !wr_cnt
    |=> main_counter == 16'h0000)
    else $error("counter not cleared on channel A match");
  a_wrap_overflow: assert property (ce && cnt_wrap && !wr_cnt
    |=> main_counter == 16'h0000 && evt_req.ovf)
    else $error("wrap did not give zero and overflow");
  a_stop_at_match: assert property (ce && cmp_hit[0] && stop_at_match_bit
    |=> !run_bit)
    else $error("count did not halt at channel A match");
  a_hold_stopped: assert property (ce && !run_bit && !wr_cnt && !wr_ctl1 && !cap_evt[0]
    |=> main_counter == $past(main_counter) && pin_drv.out == $past(pin_drv.out))
    else $error("stopped counter or pins moved");
  a_match_high: assert property (ce && cmp_hit[1] && act[1] == TCCU_ACT_HIGH && !wr_ctl1
    |=> pin_drv.out[1] && pin_drv.oe[1])
    else $error("high action did not raise the pin");
  a_init_level: assert property (wr_ctl1
    |=> pin_drv.out == $past(bus_req.wdata[3:0]))
    else $error("initial levels not driven on write");
  a_b7_reads_one: assert property (s_rd_ab |=> rd_data[7])
    else $error("unused bit did not read as one");
  a_buf_pin_off: assert property (ce && buf_en[0] |=> !pin_drv.oe[2])
    else $error("buffered channel C drove its pin");
  a_cap_request: assert property (ce && cap_evt[0] |=> evt_req.chan[0])
    else $error("capture raised no request");
  a_cmp_request: assert property (ce && cmp_hit[0] |=> evt_req.chan[0])
    else $error("compare match raised no request");

endmodule

// *** rtl/tccu_params.svh ***
`ifndef TCCU_PARAMS_SVH
`define TCCU_PARAMS_SVH

// Register offsets on the plain register port
`define TCCU_OFF_MODE 12'h120
`define TCCU_OFF_CTL1 12'h121
`define TCCU_OFF_IOAB 12'h124
`define TCCU_OFF_IOCD 12'h125
`define TCCU_OFF_CNT  12'h126
`define TCCU_OFF_GRA  12'h128
`define TCCU_OFF_GRB  12'h12A
`define TCCU_OFF_GRC  12'h12C
`define TCCU_OFF_GRD  12'h12E
`define TCCU_OFF_CTL2 12'h130

// Reset values
`define TCCU_RST_MODE 8'h00
`define TCCU_RST_CTL1 8'h00
`define TCCU_RST_IOAB 8'h88
`define TCCU_RST_IOCD 8'h88
`define TCCU_RST_CTL2 8'h18
`define TCCU_RST_GR   16'hFFFF
`define TCCU_RST_CNT  16'h0000

// Field positions
`define TCCU_MODE_RUN  7
`define TCCU_MODE_BFD  3
`define TCCU_MODE_BFC  2
`define TCCU_CTL1_CLR  7
`define TCCU_CTL1_SRC  6:4
`define TCCU_CTL1_INIT 3:0
`define TCCU_CTL2_STOP 5
`define TCCU_CH_EDGE   1:0
`define TCCU_CH_MODE   2
`define TCCU_CH_FUNC   3

// Bits that read as one whatever was written
`define TCCU_IOAB_ONES 8'h80
`define TCCU_CTL2_ONES 8'h18
// Writable bits
`define TCCU_MODE_MASK 8'h8C
`define TCCU_CTL2_MASK 8'h20

// Prescaler masks for the divided count sources
`define TCCU_PSC_W   5
`define TCCU_PSC_D2  5'h01
`define TCCU_PSC_D4  5'h03
`define TCCU_PSC_D8  5'h07
`define TCCU_PSC_D32 5'h1F

`define TCCU_CNT_MAX 16'hFFFF

`endif

// *** rtl/tccu_pkg.sv ***
package tccu_pkg;

  // Count source selection codes
  typedef enum logic [2:0] {
    TCCU_SRC_F1   = 3'h0,
    TCCU_SRC_F2   = 3'h1,
    TCCU_SRC_F4   = 3'h2,
    TCCU_SRC_F8   = 3'h3,
    TCCU_SRC_F32  = 3'h4,
    TCCU_SRC_EXT  = 3'h5,
    TCCU_SRC_FAST = 3'h6,
    TCCU_SRC_ALT  = 3'h7
  } tccu_src_t;

  // Capture edge codes
  typedef enum logic [1:0] {
    TCCU_EDGE_RISE = 2'h0,
    TCCU_EDGE_FALL = 2'h1,
    TCCU_EDGE_BOTH = 2'h2,
    TCCU_EDGE_NONE = 2'h3
  } tccu_edge_t;

  // Compare match action codes
  typedef enum logic [1:0] {
    TCCU_ACT_OFF    = 2'h0,
    TCCU_ACT_LOW    = 2'h1,
    TCCU_ACT_HIGH   = 2'h2,
    TCCU_ACT_TOGGLE = 2'h3
  } tccu_act_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } tccu_bus_req_t;

  // Event request pulses
  typedef struct packed {
    logic [3:0] chan;
    logic       ovf;
  } tccu_evt_t;

  // Channel pin drive
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } tccu_pin_drv_t;

endpackage

// *** rtl/tccu_sync_edge.sv ***
`timescale 1ns/10ps
module tccu_sync_edge #(
  parameter int N = 8
) (
  input  wire logic         ref_clk,  // Operation clock
  input  wire logic         rst_n,    // Asynchronous reset
  input  wire logic         ce,       // Clock enable
  input  wire logic [N-1:0] async_in, // Raw inputs
  output logic      [N-1:0] rise,     // One-cycle rising edge
  output logic      [N-1:0] fall      // One-cycle falling edge
);

  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;

  // Two-stage synchroniser plus a history stage per input
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
      end else if (ce) begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
      end
    end
    // Edges seen only past the second stage
    assign rise[i] = ce & s2[i] & ~s3[i];
    assign fall[i] = ce & ~s2[i] & s3[i];
  end

endmodule

// *** bench/tccu_pin_model.sv ***
`timescale 1ns/10ps
module tccu_pin_model (
  input  wire logic       ref_clk, // Operation clock
  output logic      [7:0] lines    // Pins A..D, ext pin, slow, fast, alternate
);
  // Lines stand low between trains, oscillators included
  initial lines = 8'h00;

  // Pulse train on one line, four cycles high and four low per pulse
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      lines[which] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      lines[which] <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
`include "tccu_params.svh"
module tb;
  import tccu_pkg::*;
  logic          ref_clk;
  logic          rst_n;
  tccu_bus_req_t bus_req;
  tccu_pin_drv_t pin_drv;
  tccu_evt_t     evt_req;
  logic [15:0]   rd_data;
  logic [15:0]   rv;
  logic [15:0]   rnd;
  logic [15:0]   v1;
  logic [7:0]    lines;
  logic          b;
  logic          ce;
  int            failures;
  int            n_compared;
  int            n_evt;
  int            n_ovf;
  int            divs[5] = '{1, 2, 4, 8, 32};
  int            cap_n[4] = '{1, 1, 2, 0};

  tccu_top uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .pin_drv(pin_drv),
    .evt_req(evt_req), .rd_data(rd_data), .channel_pin_in(lines[3:0]),
    .external_count_pin(lines[4]), .slow_osc_divided(lines[5]),
    .fast_osc_clock(lines[6]), .alternate_osc_clock(lines[7])
  );
  tccu_pin_model pm (.ref_clk(ref_clk), .lines(lines));

  // Clock and request counters for channel A and overflow
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (evt_req.chan[0] === 1'b1) n_evt++;
    if (evt_req.ovf === 1'b1) n_ovf++;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Register port cycles, strobes one cycle long
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 rv = rd_data;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input logic [15:0] got, input int exp);
    n_compared++;
    if ($isunknown(got) || int'(got) > exp + 2 || int'(got) + 2 < exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog far beyond the fewer than 1,500 cycles the tests take
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    rnd = 16'hC14A;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`TCCU_OFF_CTL1);
    chk(rv, 16'h0000);
    rd(`TCCU_OFF_IOCD);
    chk(rv, 16'h0088);
    rd(`TCCU_OFF_CTL2);
    chk(rv, 16'h0018);
    rd(12'h122);
    chk(rv, 16'h0000);
    wr(`TCCU_OFF_IOAB, 16'h0000);
    rd(`TCCU_OFF_IOAB);
    chk(rv, 16'h0080);
    rnd = lfsr(rnd);
    wr(`TCCU_OFF_CNT, rnd);
    rd(`TCCU_OFF_CNT);
    chk(rv, rnd);
    // Divided sources over a 72-cycle run, then pin-driven sources
    for (int s = 0; s < 8; s++) begin
      wr(`TCCU_OFF_CTL1, {9'h000, 3'(s), 4'h0});
      wr(`TCCU_OFF_CNT, 16'h0000);
      wr(`TCCU_OFF_MODE, 16'h0080);
      if (s < 5) repeat (62) @(posedge ref_clk);
      else pm.pulse((s == 5) ? 4 : s, 10);
      repeat (8) @(posedge ref_clk);
      wr(`TCCU_OFF_MODE, 16'h0000);
      rd(`TCCU_OFF_CNT);
      if (s < 5) chk_near(rv, 72 / divs[s]);
      else chk(rv, 16'h000A);
      repeat (10) @(posedge ref_clk);
      rd(`TCCU_OFF_CNT);
      chk_near(rv, (s < 5) ? 72 / divs[s] : 10);
    end
    // Free-running wrap gives one overflow
    wr(`TCCU_OFF_CTL1, 16'h0000);
    wr(`TCCU_OFF_CNT, 16'hFFF0);
    n_ovf = 0;
    wr(`TCCU_OFF_MODE, 16'h0080);
    repeat (38) @(posedge ref_clk);
    wr(`TCCU_OFF_MODE, 16'h0000);
    chk(16'(n_ovf), 16'h0001);
    rd(`TCCU_OFF_CNT);
    chk(rv, 16'h0018);
    // Clock enable low freezes a running counter; two ticks pass around it
    wr(`TCCU_OFF_MODE, 16'h0080);
    ce <= 1'b0;
    repeat (20) @(posedge ref_clk);
    ce <= 1'b1;
    wr(`TCCU_OFF_MODE, 16'h0000);
    rd(`TCCU_OFF_CNT);
    chk(rv, 16'h001A);
    // Compare actions on channel A with a random initial level
    for (int a = 1; a < 4; a++) begin
      b = rnd[0];
      rnd = lfsr(rnd);
      wr(`TCCU_OFF_IOAB, 16'(8'h08 | a | (a << 4)));
      wr(`TCCU_OFF_CTL1, {15'h0000, b});
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, pin_drv.out[0]}, {15'h0000, b});
      chk({14'h0000, pin_drv.oe[1:0]}, 16'h0003);
      wr(`TCCU_OFF_GRA, 16'h0014);
      wr(`TCCU_OFF_GRB, 16'h000A);
      wr(`TCCU_OFF_CNT, 16'h0000);
      n_evt = 0;
      wr(`TCCU_OFF_MODE, 16'h0080);
      repeat (40) @(posedge ref_clk);
      wr(`TCCU_OFF_MODE, 16'h0000);
      v1 = (a == 1) ? 16'h0000 : (a == 2) ? 16'h0001 : {15'h0000, ~b};
      chk({15'h0000, pin_drv.out[0]}, v1);
      chk({15'h0000, pin_drv.out[1]}, (a == 1) ? 16'h0000 : 16'h0001);
      chk(16'(n_evt), 16'h0001);
      repeat (10) @(posedge ref_clk);
      chk({15'h0000, pin_drv.out[0]}, v1);
    end
    // Buffered compare with clear and stop at channel A match
    rnd = lfsr(rnd);
    wr(`TCCU_OFF_CTL2, 16'h0020);
    wr(`TCCU_OFF_CTL1, 16'h0080);
    wr(`TCCU_OFF_IOAB, 16'h000A);
    wr(`TCCU_OFF_IOCD, 16'h0088);
    wr(`TCCU_OFF_GRC, rnd);
    wr(`TCCU_OFF_GRA, 16'h000F);
    wr(`TCCU_OFF_CNT, 16'h0000);
    wr(`TCCU_OFF_MODE, 16'h0084);
    repeat (40) @(posedge ref_clk);
    rd(`TCCU_OFF_MODE);
    chk(rv, 16'h0004);
    rd(`TCCU_OFF_CNT);
    chk(rv, 16'h0000);
    rd(`TCCU_OFF_GRA);
    chk(rv, rnd);
    wr(`TCCU_OFF_CTL2, 16'h0000);
    wr(`TCCU_OFF_MODE, 16'h0000);
    wr(`TCCU_OFF_CTL1, 16'h0000);
    // Capture edges on channel A with the counter held
    for (int e = 0; e < 4; e++) begin
      rnd = lfsr(rnd);
      wr(`TCCU_OFF_IOAB, 16'(8'h0C | e));
      wr(`TCCU_OFF_CNT, rnd);
      wr(`TCCU_OFF_GRA, 16'hFFFF);
      n_evt = 0;
      pm.pulse(0, 1);
      repeat (8) @(posedge ref_clk);
      chk(16'(n_evt), 16'(cap_n[e]));
      rd(`TCCU_OFF_GRA);
      chk(rv, (e == 3) ? 16'hFFFF : rnd);
    end
    // Buffered capture: C keeps the old A value
    wr(`TCCU_OFF_MODE, 16'h0004);
    wr(`TCCU_OFF_IOCD, 16'h008C);
    wr(`TCCU_OFF_IOAB, 16'h000C);
    v1 = lfsr(rnd);
    rnd = lfsr(v1);
    wr(`TCCU_OFF_CNT, v1);
    pm.pulse(0, 1);
    wr(`TCCU_OFF_CNT, rnd);
    pm.pulse(0, 1);
    repeat (8) @(posedge ref_clk);
    rd(`TCCU_OFF_GRC);
    chk(rv, v1);
    rd(`TCCU_OFF_GRA);
    chk(rv, rnd);
    // Trigger select takes the slow oscillator, not the pin
    wr(`TCCU_OFF_MODE, 16'h0000);
    wr(`TCCU_OFF_IOAB, 16'h0004);
    wr(`TCCU_OFF_CNT, v1);
    n_evt = 0;
    pm.pulse(5, 1);
    wr(`TCCU_OFF_CNT, rnd);
    pm.pulse(0, 1);
    repeat (8) @(posedge ref_clk);
    chk(16'(n_evt), 16'h0001);
    rd(`TCCU_OFF_GRA);
    chk(rv, v1);
    end_of_test();
  end
endmodule
